// ==== rtl/pll_div_pkg.sv ====
// shared types and constants for the synthesizer divider core
package pll_div_pkg;

    localparam int WORD_BITS = 20;
    localparam int ENH_BITS  = 8;
    localparam int MAIN_BITS = 9;
    localparam int REF_BITS  = 6;
    localparam int PRE_BITS  = 4;

    // prescaler terminal counts: 0..9 divides by ten, 0..10 by eleven
    localparam logic [PRE_BITS-1:0]  PRE_TOP_LOW  = 4'h9;
    localparam logic [PRE_BITS-1:0]  PRE_TOP_HIGH = 4'hA;
    localparam logic [PRE_BITS-1:0]  PRE_HALF     = 4'h5;
    localparam logic [PRE_BITS-1:0]  PRE_RESET    = 4'h0;
    localparam logic [MAIN_BITS-1:0] MAIN_RESET   = 9'h000;
    localparam logic [MAIN_BITS-1:0] MAIN_STEP    = 9'h001;
    localparam logic [REF_BITS-1:0]  REF_RESET    = 6'h00;
    localparam logic [REF_BITS-1:0]  REF_STEP     = 6'h01;
    localparam logic [WORD_BITS-1:0] WORD_RESET   = 20'h00000;
    localparam logic [ENH_BITS-1:0]  ENH_RESET    = 8'h00;
    // reserved enhancement bits 7..5 never reach the logic
    localparam logic [ENH_BITS-1:0]  ENH_USED_MASK = 8'h1F;
    localparam logic [3:0]           HI_BITS_ZERO  = 4'h0;

    // counter word, most significant bit is the first serial bit
    typedef struct packed {
        logic [1:0] ref_hi;    // ref_count 5..4
        logic [1:0] main_hi;   // main_count 8..7
        logic       bypass;    // prescaler_bypass_sel
        logic [6:0] main_lo;   // main_count 6..0
        logic [3:0] ref_lo;    // ref_count 3..0
        logic [3:0] swallow;   // swallow_count 3..0
    } counter_word_t;

    typedef struct packed {
        logic [2:0] reserved;
        logic       power_down;
        logic       counter_load;
        logic       modsel_out;
        logic       presc_out;
        logic       out_disable;
    } enh_word_t;

    typedef struct packed {
        logic       direct_mode_sel;
        logic       serial_mode_sel;
        logic       main_low_strobe;
        logic       main_high_strobe;
        logic       swallow_ref_strobe;
        logic       hop_strobe;
        logic       enhance_strobe;
        logic       serial_commit_strobe;
        logic       par_buffer_pick;
        logic       ser_buffer_pick;
        logic       enhance_enable_n;
        logic [7:0] par_bus;
    } prog_pins_t;

    // direct mode pins, same order as the low 16 bits of a counter word
    typedef struct packed {
        logic       bypass;
        logic [6:0] main_lo;
        logic [3:0] ref_lo;
        logic [3:0] swallow;
    } direct_pins_t;

endpackage

// ==== rtl/pll_div_core.sv ====
// divider chain and programming logic of an integer-N synthesizer
//
// What this block does
// - prescaled main ratio is ten times (main_count+1) plus swallow_count.
// - low bypass select enables 10/11 prescaler; high bypasses and stops it.
// - bypassed, main divider divides RF input by main_count plus one.
// - main counter is nine bits; setting one gives ratio two.
// - reference divider divides by ref_count plus one, six bits.
// - ref_count zero passes reference input straight through.
// - mode pins pick parallel, serial or direct interface.
// - parallel strobe rising edges capture the bus into primary sections.
// - parallel byte bit mapping into the three primary sections.
// - parallel hop strobe rise copies primary word into secondary.
// - parallel pick high uses primary word, low uses secondary.
// - parallel enhance strobe loads byte; acts only while enable_n low.
// - serial mode shifts twenty word bits, first bit first.
// - serial bit order matches counter word from its top bit down.
// - serial commit or hop strobe rise copies primary into secondary.
// - serial pick high uses primary word, low uses secondary.
// - enhance strobe high shifts eight bits into enhancement stage.
// - enhancement stage captured on enhance strobe fall, then gated.
// - enhancement bits: reserved, power down, load, modsel, presc, off.
// - direct mode uses pins, high count bits forced to zero.
// - power down, counter load, diagnostic select and output disable act.
// - prescaler divides by ten or eleven as modulus_select says.
module pll_div_core (
    // clocks and reset
    input  wire logic                      core_clk_in,
    input  wire logic                      rst_b_in,
    input  wire logic                      serial_clock_in,
    // serial link data
    input  wire logic                      serial_in,
    // programming and direct pins
    input  wire pll_div_pkg::prog_pins_t   prog_pins_in,
    input  wire pll_div_pkg::direct_pins_t direct_pins_in,
    // divider inputs
    input  wire logic                      rf_in,
    input  wire logic                      ref_in,
    // divider outputs
    output logic                           main_div_out,
    output logic                           ref_div_out,
    output logic                           diag_out
);
    import pll_div_pkg::*;

    // ---------------- serial clock domain ----------------
    logic [WORD_BITS-1:0] ser_word_q;
    logic [ENH_BITS-1:0]  ser_enh_q;
    logic                 ser_tgl_q;

    // strobes and mode pins are timed to serial_clock by the controller
    wire ser_shift_ok = !prog_pins_in.direct_mode_sel
                        && prog_pins_in.serial_mode_sel
                        && !prog_pins_in.serial_commit_strobe;
    wire ser_word_shift = ser_shift_ok && !prog_pins_in.enhance_strobe;
    wire ser_enh_shift  = ser_shift_ok && prog_pins_in.enhance_strobe;

    always_ff @(posedge serial_clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            ser_word_q <= WORD_RESET;
            ser_enh_q  <= ENH_RESET;
            ser_tgl_q  <= 1'b0;
        end else begin
            if (ser_word_shift) begin
                ser_word_q <= {ser_word_q[WORD_BITS-2:0], serial_in};
                ser_tgl_q  <= !ser_tgl_q;
            end
            if (ser_enh_shift) begin
                ser_enh_q <= {ser_enh_q[ENH_BITS-2:0], serial_in};
            end
        end
    end

    // ---------------- core clock domain: synchronisers ----------------
    prog_pins_t   prog_s1_q, prog_s2_q, prog_s3_q;
    direct_pins_t dir_s1_q, dir_s2_q;
    logic [1:0]   clk_s1_q, clk_s2_q, clk_s3_q;   // {rf, ref}
    logic         tgl_s1_q, tgl_s2_q, tgl_s3_q;

    always_ff @(posedge core_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            prog_s1_q <= '0;
            prog_s2_q <= '0;
            prog_s3_q <= '0;
            dir_s1_q  <= '0;
            dir_s2_q  <= '0;
            clk_s1_q  <= 2'h0;
            clk_s2_q  <= 2'h0;
            clk_s3_q  <= 2'h0;
            tgl_s1_q  <= 1'b0;
            tgl_s2_q  <= 1'b0;
            tgl_s3_q  <= 1'b0;
        end else begin
            prog_s1_q <= prog_pins_in;
            prog_s2_q <= prog_s1_q;
            prog_s3_q <= prog_s2_q;
            dir_s1_q  <= direct_pins_in;
            dir_s2_q  <= dir_s1_q;
            clk_s1_q  <= {rf_in, ref_in};
            clk_s2_q  <= clk_s1_q;
            clk_s3_q  <= clk_s2_q;
            tgl_s1_q  <= ser_tgl_q;
            tgl_s2_q  <= tgl_s1_q;
            tgl_s3_q  <= tgl_s2_q;
        end
    end

    // ---------------- mode and strobe decode ----------------
    wire       direct_mode = prog_s2_q.direct_mode_sel;
    wire       par_mode    = !direct_mode && !prog_s2_q.serial_mode_sel;
    wire       ser_mode    = !direct_mode && prog_s2_q.serial_mode_sel;
    wire [7:0] bus         = prog_s2_q.par_bus;

    wire main_low_rise  = prog_s2_q.main_low_strobe
                          && !prog_s3_q.main_low_strobe;
    wire main_high_rise = prog_s2_q.main_high_strobe
                          && !prog_s3_q.main_high_strobe;
    wire swal_ref_rise  = prog_s2_q.swallow_ref_strobe
                          && !prog_s3_q.swallow_ref_strobe;
    wire hop_rise       = prog_s2_q.hop_strobe && !prog_s3_q.hop_strobe;
    wire commit_rise    = prog_s2_q.serial_commit_strobe
                          && !prog_s3_q.serial_commit_strobe;
    wire enh_rise       = prog_s2_q.enhance_strobe
                          && !prog_s3_q.enhance_strobe;
    wire enh_fall       = !prog_s2_q.enhance_strobe
                          && prog_s3_q.enhance_strobe;
    // serial word holds still for a whole serial_clock period after a toggle
    wire word_arrived   = tgl_s2_q ^ tgl_s3_q;

    wire copy_now = (par_mode && hop_rise)
                    || (ser_mode && (hop_rise || commit_rise));
    wire enh_par_load = par_mode && enh_rise;
    wire enh_ser_load = ser_mode && enh_fall;

    // ---------------- programming words ----------------
    counter_word_t primary_q, primary_d, secondary_q;
    enh_word_t     enh_q, enh_d, enh_eff;

    always_comb begin
        primary_d = primary_q;
        if (par_mode && main_high_rise) begin
            primary_d.ref_hi  = bus[3:2];
            primary_d.main_hi = bus[1:0];
        end
        if (par_mode && main_low_rise) begin
            primary_d.bypass  = bus[7];
            primary_d.main_lo = bus[6:0];
        end
        if (par_mode && swal_ref_rise) begin
            primary_d.ref_lo  = bus[7:4];
            primary_d.swallow = bus[3:0];
        end
        if (ser_mode && word_arrived) begin
            primary_d = counter_word_t'(ser_word_q);
        end
    end

    always_comb begin
        enh_d = enh_q;
        if (enh_par_load) begin
            enh_d = enh_word_t'(bus);
        end
        if (enh_ser_load) begin
            // serial_clock is idle around the strobe fall, stage is stable
            enh_d = enh_word_t'(ser_enh_q);
        end
    end

    always_ff @(posedge core_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            primary_q   <= counter_word_t'(WORD_RESET);
            secondary_q <= counter_word_t'(WORD_RESET);
            enh_q       <= enh_word_t'(ENH_RESET);
        end else begin
            primary_q <= primary_d;
            enh_q     <= enh_d;
            if (copy_now) begin
                secondary_q <= primary_q;
            end
        end
    end

    // functions act only while enhance_enable_n is low
    assign enh_eff = prog_s2_q.enhance_enable_n
                     ? enh_word_t'(ENH_RESET)
                     : enh_word_t'(enh_q & ENH_USED_MASK);

    // ---------------- counter word selection ----------------
    counter_word_t direct_word, par_word, ser_word_sel, sel_word;
    assign direct_word  = counter_word_t'({HI_BITS_ZERO, dir_s2_q});
    assign par_word     = prog_s2_q.par_buffer_pick
                          ? primary_q : secondary_q;
    assign ser_word_sel = prog_s2_q.ser_buffer_pick
                          ? primary_q : secondary_q;
    assign sel_word     = direct_mode ? direct_word
                          : par_mode ? par_word : ser_word_sel;

    // ---------------- divider chain ----------------
    counter_word_t        applied_q;
    logic [PRE_BITS-1:0]  pre_cnt_q, pre_cnt_d;
    logic [MAIN_BITS-1:0] main_cnt_q, main_cnt_d;
    logic [REF_BITS-1:0]  ref_cnt_q, ref_cnt_d;
    logic                 presc_raw_q;
    logic                 main_div_q, ref_div_q, diag_q;

    wire run    = !enh_eff.power_down;
    wire bypass = applied_q.bypass;
    wire rf_edge  = clk_s2_q[1] && !clk_s3_q[1];
    wire ref_edge = clk_s2_q[0] && !clk_s3_q[0];
    wire [MAIN_BITS-1:0] main_m = {applied_q.main_hi, applied_q.main_lo};
    wire [REF_BITS-1:0]  ref_r  = {applied_q.ref_hi, applied_q.ref_lo};

    // eleven while fewer than swallow_count prescaler cycles have passed
    wire modulus_select = !bypass
        && (main_cnt_q < {5'h00, applied_q.swallow});
    wire [PRE_BITS-1:0] pre_top = modulus_select
                                  ? PRE_TOP_HIGH : PRE_TOP_LOW;
    // bypassed, every rf edge clocks the main counter directly
    wire presc_edge = run && rf_edge
                      && (bypass || pre_cnt_q >= pre_top);
    // >= guards against a count shrunk below the running value
    wire main_wrap  = presc_edge && (main_cnt_q >= main_m);
    wire ref_wrap   = run && ref_edge && (ref_cnt_q >= ref_r);
    wire outs_on    = run && !enh_eff.out_disable;
    // new counts only between periods unless counter load is set or power is down
    wire take_word  = main_wrap || enh_eff.counter_load || !run;

    assign pre_cnt_d = (!run || bypass) ? PRE_RESET
                     : !rf_edge ? pre_cnt_q
                     : presc_edge ? PRE_RESET
                     : pre_cnt_q + 4'h1;
    assign main_cnt_d = (!run || main_wrap) ? MAIN_RESET
                      : presc_edge ? main_cnt_q + MAIN_STEP
                      : main_cnt_q;
    assign ref_cnt_d  = (!run || ref_wrap) ? REF_RESET
                      : ref_edge ? ref_cnt_q + REF_STEP
                      : ref_cnt_q;

    wire main_div_d = outs_on && (main_cnt_q == MAIN_RESET);
    wire ref_div_d  = outs_on && ((ref_r == REF_RESET)
                      ? clk_s2_q[0] : (ref_cnt_q == REF_RESET));
    wire diag_d     = run && (enh_eff.modsel_out ? modulus_select
                      : (enh_eff.presc_out && presc_raw_q));

    always_ff @(posedge core_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            applied_q   <= counter_word_t'(WORD_RESET);
            pre_cnt_q   <= PRE_RESET;
            main_cnt_q  <= MAIN_RESET;
            ref_cnt_q   <= REF_RESET;
            presc_raw_q <= 1'b0;
            main_div_q  <= 1'b0;
            ref_div_q   <= 1'b0;
            diag_q      <= 1'b0;
        end else begin
            if (take_word) begin
                applied_q <= sel_word;
            end
            pre_cnt_q   <= pre_cnt_d;
            main_cnt_q  <= main_cnt_d;
            ref_cnt_q   <= ref_cnt_d;
            presc_raw_q <= run && !bypass && (pre_cnt_q < PRE_HALF);
            main_div_q  <= main_div_d;
            ref_div_q   <= ref_div_d;
            diag_q      <= diag_d;
        end
    end

    assign main_div_out = main_div_q;
    assign ref_div_out  = ref_div_q;
    assign diag_out     = diag_q;

    // ---------------- assertions ----------------
    // two clock domains here, so every property names its own clock
    chk_par_low_map: assert property (
        @(posedge core_clk_in) disable iff (!rst_b_in)
        par_mode && main_low_rise |=>
            primary_q.bypass == $past(bus[7])
            && primary_q.main_lo == $past(bus[6:0]))
        else $error("main low byte mapped wrongly");

    chk_hop_copy: assert property (
        @(posedge core_clk_in) disable iff (!rst_b_in)
        copy_now |=> secondary_q == $past(primary_q))
        else $error("secondary word did not take primary");

    chk_pick_word: assert property (
        @(posedge core_clk_in) disable iff (!rst_b_in)
        par_mode && !prog_s2_q.par_buffer_pick |-> sel_word == secondary_q)
        else $error("parallel pick low did not use secondary");

    chk_direct_force: assert property (
        @(posedge core_clk_in) disable iff (!rst_b_in)
        direct_mode |-> sel_word.main_hi == 2'h0
            && sel_word.ref_hi == 2'h0
            && sel_word.swallow == dir_s2_q.swallow)
        else $error("direct mode word wrong");

    chk_enh_gate: assert property (
        @(posedge core_clk_in) disable iff (!rst_b_in)
        prog_s2_q.enhance_enable_n |=> !diag_out)
        else $error("diagnostic active while enhancement disabled");

    chk_enh_fall_cap: assert property (
        @(posedge core_clk_in) disable iff (!rst_b_in)
        enh_ser_load |=> enh_q == $past(ser_enh_q))
        else $error("enhancement stage not captured on strobe fall");

    chk_ser_word_take: assert property (
        @(posedge core_clk_in) disable iff (!rst_b_in)
        ser_mode && word_arrived |=> primary_q == $past(ser_word_q))
        else $error("serial word not moved into primary");

    chk_eleven_step: assert property (
        @(posedge core_clk_in) disable iff (!rst_b_in)
        run && rf_edge && !bypass && modulus_select
            && pre_cnt_q == PRE_TOP_LOW |=> pre_cnt_q == PRE_TOP_HIGH)
        else $error("prescaler skipped its eleventh count");

    chk_main_step: assert property (
        @(posedge core_clk_in) disable iff (!rst_b_in)
        presc_edge && main_cnt_q < main_m |=>
            main_cnt_q == $past(main_cnt_q) + MAIN_STEP)
        else $error("main counter did not advance");

    // counter restarts the cycle after a wrap, output is high one cycle later while outputs are on
    chk_main_wrap: assert property (
        @(posedge core_clk_in) disable iff (!rst_b_in)
        main_wrap |=> main_cnt_q == MAIN_RESET
            ##1 main_div_out == $past(outs_on))
        else $error("main counter did not restart");

    chk_bypass_idle: assert property (
        @(posedge core_clk_in) disable iff (!rst_b_in)
        applied_q.bypass |=> pre_cnt_q == PRE_RESET)
        else $error("prescaler counts while bypassed");

    chk_ref_step: assert property (
        @(posedge core_clk_in) disable iff (!rst_b_in)
        run && ref_edge && ref_cnt_q < ref_r |=>
            ref_cnt_q == $past(ref_cnt_q) + REF_STEP)
        else $error("reference counter did not advance");

    chk_ref_through: assert property (
        @(posedge core_clk_in) disable iff (!rst_b_in)
        outs_on && ref_r == REF_RESET ##1 $stable(ref_r) && outs_on
            |-> ref_div_out == $past(clk_s2_q[0]))
        else $error("reference not passed through");

    chk_pdown_quiet: assert property (
        @(posedge core_clk_in) disable iff (!rst_b_in)
        enh_eff.power_down [*2] |-> !main_div_out && !ref_div_out
            && !diag_out && main_cnt_q == MAIN_RESET)
        else $error("outputs active in power down");

    chk_outs_off: assert property (
        @(posedge core_clk_in) disable iff (!rst_b_in)
        !outs_on |=> !main_div_out && !ref_div_out)
        else $error("divider outputs active while disabled");

    chk_load_now: assert property (
        @(posedge core_clk_in) disable iff (!rst_b_in)
        enh_eff.counter_load |=> applied_q == $past(sel_word))
        else $error("counter load did not apply counts");

    chk_ser_shift: assert property (
        @(posedge serial_clock_in) disable iff (!rst_b_in)
        ser_word_shift |=> ser_word_q[0] == $past(serial_in))
        else $error("serial bit not shifted in");

    chk_enh_shift: assert property (
        @(posedge serial_clock_in) disable iff (!rst_b_in)
        ser_enh_shift |=> ser_enh_q[0] == $past(serial_in))
        else $error("enhancement bit not shifted in");

    cov_par_hop: cover property (
        @(posedge core_clk_in) par_mode && hop_rise);
    cov_ser_commit: cover property (
        @(posedge core_clk_in) ser_mode && commit_rise);
    cov_enh_capture: cover property (
        @(posedge core_clk_in) enh_ser_load);
    cov_swallow_wrap: cover property (@(posedge core_clk_in)
        main_wrap && applied_q.swallow != 4'h0 && !bypass);
    cov_power_down: cover property (
        @(posedge core_clk_in) enh_eff.power_down);

endmodule

// ==== verification/prog_ctrl_model.sv ====
// controller model driving programming strobes and the serial link
module prog_ctrl_model (
    // core clock used for strobe timing
    input  wire logic                    core_clk_in,
    // programming pins and serial link
    output pll_div_pkg::prog_pins_t      pins_out,
    output logic                         sclk_out,
    output logic                         sdata_out
);
    timeunit 1ns;
    timeprecision 1ps;
    import pll_div_pkg::*;

    initial begin
        pins_out = '0;
        pins_out.enhance_enable_n = 1'b1;
        sclk_out = 1'b0;
        sdata_out = 1'b0;
    end

    task automatic cycles(input int n);
        repeat (n) @(negedge core_clk_in);
    endtask

    // mode and pick pins are levels held between transfers
    task automatic levels(input logic dm, sm, pp, sp, en);
        cycles(1);
        pins_out.direct_mode_sel  = dm;
        pins_out.serial_mode_sel  = sm;
        pins_out.par_buffer_pick  = pp;
        pins_out.ser_buffer_pick  = sp;
        pins_out.enhance_enable_n = en;
        cycles(10);
    endtask

    task automatic strobe(input int which, input logic v);
        case (which)
            0: pins_out.main_low_strobe    = v;
            1: pins_out.main_high_strobe   = v;
            2: pins_out.swallow_ref_strobe = v;
            3: pins_out.hop_strobe         = v;
            default: pins_out.enhance_strobe = v;
        endcase
    endtask

    // byte settles well before the rise; pulse is 40 ns, above minimum
    task automatic par_write(input int which, input logic [7:0] b);
        cycles(1);
        pins_out.par_bus = b;
        cycles(4);
        strobe(which, 1'b1);
        cycles(10);
        strobe(which, 1'b0);
        cycles(6);
        pins_out.par_bus = ~b; // released bus shows no stale byte
    endtask

    // clock only runs inside a frame, first bit first
    task automatic shift(input logic [19:0] bits, input int n);
        for (int i = n - 1; i >= 0; i--) begin
            sdata_out = bits[i];
            #62.5 sclk_out = 1'b1;
            #62.5 sclk_out = 1'b0;
        end
        sdata_out = ~sdata_out;
    endtask

    task automatic commit();
        cycles(10);
        pins_out.serial_commit_strobe = 1'b1;
        cycles(10);
        pins_out.serial_commit_strobe = 1'b0;
        cycles(10);
    endtask

    task automatic enh_serial(input logic [7:0] b);
        cycles(1);
        pins_out.enhance_strobe = 1'b1;
        cycles(10);
        shift({12'h000, b}, 8);
        cycles(10);
        pins_out.enhance_strobe = 1'b0;
        cycles(20);
    endtask
endmodule

// ==== verification/pll_div_programming_tb.sv ====
// self-checking bench for the divider core and its programming paths
`define CHK(nm, exp, got) begin check_count++; if ((got) !== (exp)) begin \
    fail_count++; $display("wrong value %s expected %0d seen %0d", \
    nm, exp, got); end end
module pll_div_programming_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import pll_div_pkg::*;

    logic         core_clk_in = 1'b0;
    logic         rst_b_in    = 1'b0;
    logic         rf_in       = 1'b0;
    logic         ref_in      = 1'b0;
    direct_pins_t dpins       = '0;
    prog_pins_t   pins;
    logic         sclk;
    logic         sdata;
    logic         main_o;
    logic         ref_o;
    logic         diag_o;
    logic         pick_diag   = 1'b0;
    int           fail_count  = 0;
    int           check_count = 0;

    // rf period 40 ns and ref 48 ns: exact multiples of the core period
    always #2 core_clk_in = ~core_clk_in;
    always #20 rf_in = ~rf_in;
    always #24 ref_in = ~ref_in;

    prog_ctrl_model ctrl (
        .core_clk_in (core_clk_in),
        .pins_out    (pins),
        .sclk_out    (sclk),
        .sdata_out   (sdata)
    );

    pll_div_core DUT (
        .core_clk_in     (core_clk_in),
        .rst_b_in        (rst_b_in),
        .serial_clock_in (sclk),
        .serial_in       (sdata),
        .prog_pins_in    (pins),
        .direct_pins_in  (dpins),
        .rf_in           (rf_in),
        .ref_in          (ref_in),
        .main_div_out    (main_o),
        .ref_div_out     (ref_o),
        .diag_out        (diag_o)
    );

    // interval between the 2nd and 3rd rise, so old counts have drained
    task automatic period(input logic sel, output int ns);
        int     r;
        longint t0;
        logic   prev;
        logic   cur;
        r = 0;
        t0 = 0;
        ns = -1;
        prev = 1'b1;
        for (int k = 0; k < 8000 && r < 3; k++) begin
            @(negedge core_clk_in);
            cur = pick_diag ? diag_o : sel ? ref_o : main_o;
            if (cur === 1'b1 && prev !== 1'b1) begin
                r++;
                if (r == 3) ns = int'($time - t0);
                t0 = $time;
            end
            prev = cur;
        end
    endtask

    task automatic s_par_bypass();
        int p;
        ctrl.levels(1'b0, 1'b0, 1'b1, 1'b0, 1'b1);
        ctrl.par_write(0, 8'h83);
        ctrl.par_write(1, 8'h05);
        ctrl.par_write(2, 8'h20);
        period(1'b0, p);
        `CHK("main bypass", 132 * 40, p)
        period(1'b1, p);
        `CHK("ref ratio", 19 * 48, p)
    endtask

    task automatic s_par_hop();
        int p;
        ctrl.par_write(1, 8'h00);
        ctrl.par_write(0, 8'h01);
        ctrl.par_write(2, 8'h02);
        ctrl.par_write(3, 8'h00);
        ctrl.par_write(0, 8'h83);
        ctrl.levels(1'b0, 1'b0, 1'b0, 1'b0, 1'b1);
        period(1'b0, p);
        `CHK("main prescaled", 22 * 40, p)
        period(1'b1, p);
        `CHK("ref thru", 48, p)
    endtask

    task automatic s_serial();
        int            p;
        counter_word_t w;
        w = '0;
        w.bypass  = 1'b1;
        w.main_lo = 7'h05;
        ctrl.levels(1'b0, 1'b1, 1'b0, 1'b0, 1'b1);
        ctrl.shift(w, 20);
        ctrl.commit();
        period(1'b0, p);
        `CHK("serial word", 6 * 40, p)
        w.main_lo = 7'h01;
        ctrl.shift(w, 20);
        ctrl.levels(1'b0, 1'b1, 1'b0, 1'b1, 1'b1);
        period(1'b0, p);
        `CHK("serial primary", 2 * 40, p)
    endtask

    // reserved bits set too: they must change nothing
    task automatic s_enh();
        int p;
        int hi;
        hi = 0;
        ctrl.enh_serial(8'hE1);
        ctrl.levels(1'b0, 1'b1, 1'b0, 1'b1, 1'b0);
        repeat (400) begin
            @(negedge core_clk_in);
            if (main_o !== 1'b0 || ref_o !== 1'b0) hi++;
        end
        `CHK("disabled outs", 0, hi)
        ctrl.levels(1'b0, 1'b1, 1'b0, 1'b1, 1'b1);
        period(1'b0, p);
        `CHK("enh gated off", 2 * 40, p)
    endtask

    task automatic s_direct();
        int p;
        dpins.bypass  = 1'b1;
        dpins.main_lo = 7'h02;
        dpins.ref_lo  = 4'h1;
        dpins.swallow = 4'h0;
        ctrl.levels(1'b1, 1'b1, 1'b0, 1'b0, 1'b1);
        period(1'b0, p);
        `CHK("direct main", 3 * 40, p)
        period(1'b1, p);
        `CHK("direct ref", 2 * 48, p)
    endtask

    // parallel enhancement loads: prescaler tap, modulus tap, power down
    task automatic s_par_enh();
        int p;
        int hi;
        hi = 0;
        ctrl.levels(1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
        ctrl.par_write(0, 8'h01);
        ctrl.par_write(4, 8'h0A);
        period(1'b0, p);
        `CHK("main div ten", 20 * 40, p)
        pick_diag = 1'b1;
        period(1'b0, p);
        `CHK("diag prescaler", 10 * 40, p)
        ctrl.par_write(2, 8'h01);
        ctrl.par_write(4, 8'h04);
        period(1'b0, p);
        `CHK("diag modulus", 21 * 40, p)
        pick_diag = 1'b0;
        ctrl.par_write(4, 8'h10);
        repeat (400) begin
            @(negedge core_clk_in);
            if (main_o !== 1'b0 || ref_o !== 1'b0 || diag_o !== 1'b0) hi++;
        end
        `CHK("power down outs", 0, hi)
        ctrl.par_write(4, 8'h00);
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // all scenarios take well under 150 us
    initial begin
        #300us;
        fail_count++;
        test_done();
    end

    initial begin
        repeat (8) @(negedge core_clk_in);
        rst_b_in = 1'b1;
        repeat (6) @(negedge core_clk_in);
        s_par_bypass();
        s_par_hop();
        s_serial();
        s_enh();
        s_par_enh();
        s_direct();
        test_done();
    end
endmodule
